/* rtl/bdm_map.sv */
// Purpose: Banked data memory map with bank select and two indirect pointers
// Assumes: Memory array answers mem_rdata and mem_present in the cycle of the request
// Notes: Program memory reads take one more cycle than data accesses
//
// Summary of operation
// - Pointer high byte bit 7 set sends port reads to program memory.
// - Move indirect to work loads only the program word's low 8 bits.
// - Writes through the ports aimed at program memory change nothing.
// - Program memory reached through a pointer costs one extra cycle.
// - Data space is 32 banks of 128 byte addresses.
// - Each bank holds core registers, 20 special registers, up to 80 RAM bytes.
// - Each bank also shows 16 bytes of common RAM.
// - Direct accesses use the bank last written to the bank select register.
// - Unimplemented locations read as zero.
// - First 12 offsets of every bank are the same core registers.
// - All data reachable directly and through either pointer.
`include "bdm_consts.svh"

module bdm_map (
   input wire logic clk,
   input wire logic rst_b,
   input wire bdm_pkg::bdm_req_t req,
   output logic ready,
   output bdm_pkg::bdm_rsp_t rsp,
   output bdm_pkg::bdm_mem_t mem,
   input wire logic [7:0] mem_rdata,
   input wire logic mem_present,
   output bdm_pkg::bdm_prog_t prog,
   input wire logic [13:0] prog_rdata
);

   logic rst_meta_b;
   logic rst_sync_b;
   bdm_pkg::bdm_state_t st;
   bdm_pkg::bdm_state_t next_st;
   bdm_pkg::bdm_region_t region;
   logic [3:0] core_idx;
   logic [3:0] common_idx;
   logic [15:0] ptr;
   logic [4:0] bank_sel;
   logic [4:0] bank;
   logic take;
   logic prog_sel;
   logic ram_here;
   logic [7:0] rd_byte;

   // Reset is released synchronously so no flop leaves reset on a different edge
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta_b <= 1'b0;
         rst_sync_b <= 1'b0;
      end else begin
         rst_meta_b <= 1'b1;
         rst_sync_b <= rst_meta_b;
      end
   end

   assign bank_sel = st.core[`BDM_OFS_BANK][`BDM_BANK_MSB:0];
   assign ready = (st.phase == bdm_pkg::BDM_IDLE);
   assign take = req.valid && ready;

   always_comb begin
      if (req.indirect) begin
         if (req.ptr_sel) begin
            ptr = {st.core[`BDM_OFS_PTR1_HI], st.core[`BDM_OFS_PTR1_LO]};
         end else begin
            ptr = {st.core[`BDM_OFS_PTR0_HI], st.core[`BDM_OFS_PTR0_LO]};
         end
      end else begin
         ptr = {`BDM_PTR_PAD, bank_sel, req.offset};
      end
   end

   assign bank = ptr[11:7];
   assign prog_sel = req.indirect && ptr[`BDM_PROG_BIT];

   bdm_region_decode u_decode (
      .offset(ptr[6:0]),
      .region(region),
      .core_idx(core_idx),
      .common_idx(common_idx)
   );

   // General purpose RAM exists only in the lower banks
   assign ram_here = (region == bdm_pkg::BDM_REG_RAM) && (bank < `BDM_RAM_BANKS);

   assign mem.valid = take && !prog_sel
      && ((region == bdm_pkg::BDM_REG_SPECIAL) || ram_here);
   assign mem.write = req.write;
   assign mem.addr = ptr[11:0];
   assign mem.wdata = req.wdata;

   assign prog.valid = (st.phase == bdm_pkg::BDM_PROG_WAIT) && !st.pend_write;
   assign prog.addr = st.prog_addr;
   assign rsp = st.rsp;

   // Read data for a data memory access
   always_comb begin
      rd_byte = `BDM_BYTE_ZERO;
      case (region)
         bdm_pkg::BDM_REG_CORE: begin
            // Ports themselves hold nothing and read as zero
            if (core_idx != `BDM_OFS_PORT0 && core_idx != `BDM_OFS_PORT1) begin
               rd_byte = st.core[core_idx];
            end
         end
         bdm_pkg::BDM_REG_COMMON: begin
            rd_byte = st.common[common_idx];
         end
         default: begin
            if (mem.valid && mem_present) begin
               rd_byte = mem_rdata;
            end else begin
               rd_byte = `BDM_BYTE_ZERO;
            end
         end
      endcase
   end

   always_comb begin
      next_st = st;
      next_st.rsp.valid = 1'b0;
      next_st.rsp.working_register_load = 1'b0;
      case (st.phase)
         bdm_pkg::BDM_IDLE: begin
            if (take && prog_sel) begin
               next_st.phase = bdm_pkg::BDM_PROG_WAIT;
               next_st.prog_addr = ptr[14:0];
               next_st.pend_write = req.write;
               next_st.pend_work = req.to_work && !req.write;
            end else if (take) begin
               next_st.rsp.valid = 1'b1;
               next_st.rsp.data = req.write ? `BDM_BYTE_ZERO : rd_byte;
               if (req.write) begin
                  if (region == bdm_pkg::BDM_REG_CORE
                        && core_idx != `BDM_OFS_PORT0 && core_idx != `BDM_OFS_PORT1) begin
                     next_st.core[core_idx] = req.wdata;
                     if (core_idx == `BDM_OFS_BANK) begin
                        // Bank select keeps only its implemented bits
                        next_st.core[core_idx] = {3'h0, req.wdata[`BDM_BANK_MSB:0]};
                     end
                  end else if (region == bdm_pkg::BDM_REG_COMMON) begin
                     next_st.common[common_idx] = req.wdata;
                  end
               end else if (req.to_work) begin
                  next_st.rsp.working_register_load = 1'b1;
                  next_st.core[`BDM_OFS_WORK] = rd_byte;
               end
            end
         end
         bdm_pkg::BDM_PROG_WAIT: begin
            next_st.phase = bdm_pkg::BDM_IDLE;
            next_st.rsp.valid = 1'b1;
            // A write aimed at program memory is dropped here
            next_st.rsp.data = st.pend_write ? `BDM_BYTE_ZERO
               : prog_rdata[`BDM_LOW_BYTE_MSB:0];
            if (st.pend_work) begin
               next_st.rsp.working_register_load = 1'b1;
               next_st.core[`BDM_OFS_WORK] = prog_rdata[`BDM_LOW_BYTE_MSB:0];
            end
         end
         default: begin
            next_st.phase = bdm_pkg::BDM_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_sync_b);

   prog_redirect_a: assert property (
      take && prog_sel && !req.write |=> prog.valid && prog.addr == $past(ptr[14:0]))
      else $error("pointer bit 7 read did not reach program memory");

   work_low_byte_a: assert property (
      prog.valid && st.pend_work
      |=> rsp.working_register_load && rsp.data == $past(prog_rdata[7:0])
         && st.core[`BDM_OFS_WORK] == $past(prog_rdata[7:0]))
      else $error("work register not loaded with low program byte");

   prog_no_write_a: assert property (
      take && prog_sel && req.write |-> !mem.valid ##1 !prog.valid ##1 rsp.valid)
      else $error("program memory write had an effect");

   extra_cycle_a: assert property (
      take && prog_sel |=> !ready && !rsp.valid ##1 rsp.valid && ready)
      else $error("program access did not take one extra cycle");

   data_cycle_a: assert property (
      take && !prog_sel |=> rsp.valid && ready)
      else $error("data access did not answer in one cycle");

   bank_select_a: assert property (
      take && !req.indirect && mem.valid
      |-> mem.addr == {bank_sel, req.offset})
      else $error("direct access used the wrong bank");

   unimpl_zero_a: assert property (
      take && !req.write && !prog_sel && region != bdm_pkg::BDM_REG_CORE
      && region != bdm_pkg::BDM_REG_COMMON && !(mem.valid && mem_present)
      |=> rsp.data == 8'h00)
      else $error("unimplemented location did not read zero");

   core_shared_a: assert property (
      take && !req.indirect && req.write && req.offset == 7'h08
      |=> bank_sel == $past(req.wdata[4:0]))
      else $error("bank select not written from an arbitrary bank");

   common_local_a: assert property (
      take && region == bdm_pkg::BDM_REG_COMMON |-> !mem.valid)
      else $error("common RAM access leaked to the array port");

   indirect_reach_a: assert property (
      take && req.indirect && !prog_sel && mem.valid
      |-> mem.addr == $sampled(ptr[11:0]) && !prog.valid)
      else $error("indirect access used the wrong address");

endmodule

/* rtl/bdm_consts.svh */
// Purpose: Named offsets and field positions of the banked data memory map
// Assumes: Included by bare name from the design files
// Notes: Region boundaries are seven-bit in-bank offsets; core register offsets are four bits
`ifndef BDM_CONSTS_SVH
`define BDM_CONSTS_SVH

// In-bank region boundaries (first offset past each region)
`define BDM_CORE_END 7'h0C
`define BDM_SPECIAL_END 7'h20
`define BDM_RAM_END 7'h70
`define BDM_COMMON_MASK 7'h0F

// Core register offsets
`define BDM_OFS_PORT0 4'h0
`define BDM_OFS_PORT1 4'h1
`define BDM_OFS_PTR0_LO 4'h4
`define BDM_OFS_PTR0_HI 4'h5
`define BDM_OFS_PTR1_LO 4'h6
`define BDM_OFS_PTR1_HI 4'h7
`define BDM_OFS_BANK 4'h8
`define BDM_OFS_WORK 4'h9

// Field positions
`define BDM_PROG_BIT 15
`define BDM_BANK_MSB 4
`define BDM_LOW_BYTE_MSB 7

// Banks that hold general purpose RAM: 0 up to this value, exclusive
`define BDM_RAM_BANKS 5'h03

`define BDM_BYTE_ZERO 8'h00
`define BDM_PTR_PAD 4'h0

`endif

/* rtl/bdm_pkg.sv */
// Purpose: Types shared by the banked data memory map design
// Assumes: Constants live in bdm_consts.svh
// Notes: Nothing here is imported; users write bdm_pkg::name
package bdm_pkg;

   typedef enum logic [1:0] {
      BDM_REG_CORE,
      BDM_REG_SPECIAL,
      BDM_REG_RAM,
      BDM_REG_COMMON
   } bdm_region_t;

   typedef enum logic {
      BDM_IDLE,
      BDM_PROG_WAIT
   } bdm_phase_t;

   // Access request from the instruction execution logic
   typedef struct packed {
      logic valid;
      logic write;
      logic indirect;
      logic ptr_sel;
      logic to_work;
      logic [6:0] offset;
      logic [7:0] wdata;
   } bdm_req_t;

   typedef struct packed {
      logic valid;
      logic working_register_load;
      logic [7:0] data;
   } bdm_rsp_t;

   // Special function register and general purpose RAM array port
   typedef struct packed {
      logic valid;
      logic write;
      logic [11:0] addr;
      logic [7:0] wdata;
   } bdm_mem_t;

   typedef struct packed {
      logic valid;
      logic [14:0] addr;
   } bdm_prog_t;

   typedef struct packed {
      bdm_phase_t phase;
      logic [11:0][7:0] core;
      logic [15:0][7:0] common;
      logic [14:0] prog_addr;
      logic pend_write;
      logic pend_work;
      bdm_rsp_t rsp;
   } bdm_state_t;

endpackage

/* rtl/bdm_region_decode.sv */
// Purpose: Classifies an in-bank offset into its region
// Assumes: Every bank shares one layout
// Notes: Purely combinational
`include "bdm_consts.svh"

module bdm_region_decode (
   input wire logic [6:0] offset,
   output bdm_pkg::bdm_region_t region,
   output logic [3:0] core_idx,
   output logic [3:0] common_idx
);

   always_comb begin
      core_idx = offset[3:0];
      common_idx = offset[3:0];
      if (offset < `BDM_CORE_END) begin
         region = bdm_pkg::BDM_REG_CORE;
      end else if (offset < `BDM_SPECIAL_END) begin
         region = bdm_pkg::BDM_REG_SPECIAL;
      end else if (offset < `BDM_RAM_END) begin
         region = bdm_pkg::BDM_REG_RAM;
      end else begin
         region = bdm_pkg::BDM_REG_COMMON;
      end
   end

endmodule

/* dv/bdm_mem_model.sv */
// Purpose: Memory arrays behind the banked map: data RAM and program memory
// Assumes: Answers combinationally in the cycle of the request
// Notes: RAM starts at EE so a zero-fill from the map is told apart from stored data
module bdm_mem_model (
   input wire logic clk,
   input wire bdm_pkg::bdm_mem_t mem,
   output logic [7:0] mem_rdata,
   output logic mem_present,
   input wire bdm_pkg::bdm_prog_t prog,
   output logic [13:0] prog_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] ram [0:4095];
   logic [13:0] word;
   initial begin
      for (int i = 0; i < 4096; i++) begin
         ram[i] = 8'hEE;
      end
   end
   // One special slot left unimplemented in every bank
   assign mem_present = mem.valid && (mem.addr[6:0] != 7'h1F);
   // Idle outputs show the inverse so a stale sample cannot pass
   assign mem_rdata = mem.valid ? ram[mem.addr] : ~ram[mem.addr];
   assign word = {prog.addr[13:8], prog.addr[7:0] ^ 8'hC3};
   assign prog_rdata = prog.valid ? word : ~word;
   always @(posedge clk) begin
      if (mem.valid && mem.write) begin
         ram[mem.addr] <= mem.wdata;
      end
   end
endmodule

/* dv/tb_banked_data_memory_map.sv */
// Purpose: Self-checking bench of the banked data memory map
// Assumes: Row code is flags(wr,ind,ptr1,work), offset, write data, expected read
// Notes: One idle cycle between requests keeps program accesses legal
module tb_banked_data_memory_map;
   timeunit 1ns;
   timeprecision 1ns;
   `define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
      $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
   logic clk, rst_b, ready, mem_present, wl, rdy;
   logic [7:0] mem_rdata, d;
   logic [13:0] prog_rdata;
   logic [4:0] bank;
   bdm_pkg::bdm_req_t req;
   bdm_pkg::bdm_rsp_t rsp;
   bdm_pkg::bdm_mem_t mem, m;
   bdm_pkg::bdm_prog_t prog, pg;
   int lat, bad_count, total_checks;
   logic [27:0] rows [0:26] = '{
      28'h8_08_01_00, 28'h8_20_A5_00, 28'h8_08_00_00, 28'h8_20_3C_00, 28'h0_20_00_3C,
      28'h8_08_01_00, 28'h0_20_00_A5, 28'h8_70_5A_00, 28'h8_08_02_00, 28'h0_70_00_5A,
      28'h1_70_00_5A, 28'h0_09_00_5A, 28'h8_0A_77_00, 28'h8_08_05_00, 28'h0_0A_00_77,
      28'h0_20_00_00, 28'h0_1F_00_00, 28'h0_08_00_05, 28'h8_05_00_00, 28'h8_04_A0_00,
      28'h4_00_00_A5, 28'h8_07_01_00, 28'h8_06_20_00, 28'hE_00_99_00, 28'h6_00_00_99,
      28'h8_08_02_00, 28'h0_20_00_99};

   bdm_map dut (
      .clk(clk),
      .rst_b(rst_b),
      .req(req),
      .ready(ready),
      .rsp(rsp),
      .mem(mem),
      .mem_rdata(mem_rdata),
      .mem_present(mem_present),
      .prog(prog),
      .prog_rdata(prog_rdata)
   );

   bdm_mem_model far (
      .clk(clk),
      .mem(mem),
      .mem_rdata(mem_rdata),
      .mem_present(mem_present),
      .prog(prog),
      .prog_rdata(prog_rdata)
   );

   initial begin
      clk = 1'h0;
      forever #25 clk = ~clk;
   end

   task wrap_up;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic acc(input logic [27:0] r);
      int n;
      n = 0;
      rdy = 1'h1;
      pg = '0;
      req = '{1'h1, r[27], r[26], r[25], r[24], r[22:16], r[15:8]};
      #10 m = mem;
      @(posedge clk);
      #1 req.valid = 1'h0;
      while (rsp.valid !== 1'h1 && n < 8) begin
         n++;
         rdy = ready;
         pg = prog;
         @(posedge clk);
         #1;
      end
      lat = n + 1;
      d = rsp.data;
      wl = rsp.working_register_load;
      @(posedge clk);
      #1;
   endtask

   // About 90 cycles are needed; 2000 means a hang
   initial begin
      #100000;
      bad_count++;
      wrap_up;
   end

   initial begin
      rst_b = 1'h0;
      req = '0;
      bank = 5'h00;
      bad_count = 0;
      total_checks = 0;
      repeat (8) @(posedge clk);
      #1 rst_b = 1'h1;
      repeat (3) @(posedge clk);
      #1;
      foreach (rows[i]) begin
         acc(rows[i]);
         if (!rows[i][27]) `CHK("rdata", rows[i][7:0], d)
         `CHK("latency", 1, lat)
         if (rows[i][22:16] == 7'h20 && !rows[i][26] && bank < 5'h03)
            `CHK("mem_addr", {1'h1, bank, 7'h20}, {m.valid, m.addr})
         if (rows[i][27] && rows[i][22:16] == 7'h08) bank = rows[i][12:8];
      end
      acc(28'h8_07_81_00);
      acc(28'h8_06_34_00);
      acc(28'h7_00_00_00);
      `CHK("prog_lat", 2, lat)
      `CHK("prog_ready", 1'h0, rdy)
      `CHK("prog_addr", {1'h1, 15'h0134}, {pg.valid, pg.addr})
      `CHK("prog_data", {1'h1, 8'hF7}, {wl, d})
      `CHK("prog_rd_data_port", 1'h0, m.valid)
      acc(28'h0_09_00_00);
      `CHK("work", 8'hF7, d)
      acc(28'hE_00_55_00);
      `CHK("prog_wr", {1'h0, 8'h00}, {m.valid, d})
      `CHK("prog_wr_port", 1'h0, pg.valid)
      `CHK("prog_wr_lat", 2, lat)
      acc(28'h6_00_00_00);
      `CHK("prog_again", 8'hF7, d)
      rst_b = 1'h0;
      repeat (2) @(posedge clk);
      #1 `CHK("rst_out", 3'h4, {ready, rsp.valid, prog.valid})
      rst_b = 1'h1;
      repeat (3) @(posedge clk);
      #1;
      acc(28'h0_08_00_00);
      `CHK("bank_rst", 8'h00, d)
      acc(28'h0_20_00_00);
      `CHK("bank0_gpr", 8'h3C, d)
      wrap_up;
   end
endmodule
